// File: include/preclear_pkg.sv
package preclear_pkg;
   // Operation selects presented by the instruction decoder
   typedef enum logic [1:0] {
      OP_NONE,
      OP_FIRST_PRECLEAR,
      OP_SECOND_PRECLEAR,
      OP_COMPLEMENT
   } op_t;

   localparam int DATA_WIDTH  = 8;
   localparam int ADDR_WIDTH  = 8;
   // Neither half of the pair pending after reset
   localparam logic [1:0] PAIR_RESET = 2'h0;
   localparam logic [1:0] PAIR_FIRST = 2'h1;
   localparam logic [1:0] PAIR_SECOND = 2'h2;
   // Complement sequence: read cycle then write cycle
   localparam int RMW_CYCLES  = 2;
endpackage

// File: include/mem_port_if.sv
interface mem_port_if #(
   parameter int AW = 8,
   parameter int DW = 8
);
   logic          rd_en;
   logic          wr_en;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;

   modport master (output rd_en, output wr_en, output addr, output wdata, input rdata);
   modport slave  (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface

// File: rtl/complement_rmw.sv
// Read-modify-write engine: reads a byte, writes its ones' complement back
module complement_rmw #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input  wire logic          i_clk,
   input  wire logic          i_rst,
   input  wire logic          i_start,
   input  wire logic [AW-1:0] i_addr,
   output logic               o_busy,
   output logic               o_done,
   mem_port_if.master         mem
);
   typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} rmw_state_t;
   rmw_state_t    state_reg;
   rmw_state_t    state_next;
   logic [AW-1:0] addr_reg;
   logic [DW-1:0] wdata_reg;

   // Next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:  if (i_start) state_next = ST_READ;
         ST_READ:  state_next = ST_WRITE;
         ST_WRITE: state_next = ST_IDLE;
         default:  state_next = ST_IDLE;
      endcase
   end

   // State, latched address and inverted data
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_reg <= ST_IDLE;
         addr_reg  <= '0;
         wdata_reg <= '0;
      end else begin
         state_reg <= state_next;
         if (state_reg == ST_IDLE && i_start) addr_reg <= i_addr;
         if (state_reg == ST_READ) wdata_reg <= ~mem.rdata; // [RULE5]
      end
   end

   // Same address on both halves keeps the write on the operand's location
   assign mem.addr  = addr_reg;                       // [RULE6]
   assign mem.rd_en = (state_reg == ST_READ);
   assign mem.wr_en = (state_reg == ST_WRITE);        // [RULE6]
   assign mem.wdata = wdata_reg;
   assign o_busy    = (state_reg != ST_IDLE);
   assign o_done    = (state_reg == ST_WRITE);

   read_then_write_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE6]
      mem.rd_en |=> mem.wr_en && mem.addr == $past(mem.addr))
      else $error("write does not follow read at same address");
   inverted_data_a: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE5]
      mem.rd_en |=> mem.wdata == ~$past(mem.rdata))
      else $error("written byte is not the complement");
endmodule // complement_rmw

// File: rtl/preclear_complement.sv
// What this block does
// RULE1: Effective pre-clear resets watchdog counter, clears time-out and power-down flags.
// RULE2: Second pre-clear is effective only after the first pre-clear; the code also makes a first pre-clear effective after an unpaired second.
// RULE3: Repeated second pre-clear without first between changes nothing.
// RULE4: Repeated first pre-clear without second between changes nothing.
// RULE5: Complement instruction inverts every bit of the addressed byte.
// RULE6: Inverted byte goes back to the same address in one read-modify-write.
module preclear_complement #(
   parameter int AW = preclear_pkg::ADDR_WIDTH,
   parameter int DW = preclear_pkg::DATA_WIDTH
) (
   input  wire logic                 I_CORE_CLK,
   input  wire logic                 I_RST,
   input  wire logic                 i_op_valid,
   input  wire preclear_pkg::op_t    i_op,
   input  wire logic [AW-1:0]        i_op_addr,
   input  wire logic                 i_timeout_set,
   input  wire logic                 i_power_down_set,
   output logic                      o_op_ready,
   output logic                      o_wdt_clear,
   output logic                      o_watchdog_timeout_flag,
   output logic                      o_power_down_flag,
   output logic                      o_mem_rd_en,
   output logic                      o_mem_wr_en,
   output logic [AW-1:0]             o_mem_addr,
   output logic [DW-1:0]             o_mem_wdata,
   input  wire logic [DW-1:0]        i_mem_rdata
);
   // Zero widths would leave the address and data buses empty
   if (AW < 1 || DW < 1) begin : g_bad_width
      $error("widths must be positive");
   end

   mem_port_if #(.AW(AW), .DW(DW)) mem ();
   logic       rmw_busy;
   logic [1:0] pair_reg;
   logic [1:0] pair_next;
   logic       wdt_clear_reg;
   logic       timeout_reg;
   logic       power_down_reg;
   logic [1:0] stall_cnt_reg;

   // Opcode compare shared by the three decodes
   function automatic logic op_is(input preclear_pkg::op_t code, input preclear_pkg::op_t want);
      return code == want;
   endfunction

   // Decode of accepted instructions; stall while the memory sequence runs
   wire take        = i_op_valid && !rmw_busy;
   wire is_first    = take && op_is(i_op, preclear_pkg::OP_FIRST_PRECLEAR);
   wire is_second   = take && op_is(i_op, preclear_pkg::OP_SECOND_PRECLEAR);
   wire is_cpl      = take && op_is(i_op, preclear_pkg::OP_COMPLEMENT);
   // Each half fires only if the other half was the last one seen
   wire first_eff   = is_first && (pair_reg == preclear_pkg::PAIR_SECOND);  // [RULE4]
   wire second_eff  = is_second && (pair_reg == preclear_pkg::PAIR_FIRST);  // [RULE2] [RULE3]
   wire clear_fire  = first_eff || second_eff;

   // Track last pre-clear; an effective clear rearms so both halves are needed again
   always_comb begin
      pair_next = pair_reg;
      if (clear_fire) pair_next = preclear_pkg::PAIR_RESET;               // [RULE2]
      else if (is_first) pair_next = preclear_pkg::PAIR_FIRST;
      else if (is_second) pair_next = preclear_pkg::PAIR_SECOND;
   end

   // Pair tracker and clear pulse
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         pair_reg      <= preclear_pkg::PAIR_RESET;
         wdt_clear_reg <= 1'b0;
      end else begin
         pair_reg      <= pair_next;
         wdt_clear_reg <= clear_fire;                                     // [RULE1]
      end
   end

   // Flags: hardware set wins over instruction clear so no time-out is lost
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         timeout_reg    <= 1'b0;
         power_down_reg <= 1'b0;
      end else begin
         if (i_timeout_set) timeout_reg <= 1'b1;
         else if (clear_fire) timeout_reg <= 1'b0;                        // [RULE1]
         if (i_power_down_set) power_down_reg <= 1'b1;
         else if (clear_fire) power_down_reg <= 1'b0;                     // [RULE1]
      end
   end

   complement_rmw #(.AW(AW), .DW(DW)) u_rmw (
      .i_clk   (I_CORE_CLK),
      .i_rst   (I_RST),
      .i_start (is_cpl),                                                  // [RULE5]
      .i_addr  (i_op_addr),
      .o_busy  (rmw_busy),
      .o_done  (),
      .mem     (mem.master)
   );

   // Memory port and status outputs
   assign mem.rdata               = i_mem_rdata;
   assign o_mem_rd_en             = mem.rd_en;
   assign o_mem_wr_en             = mem.wr_en;
   assign o_mem_addr              = mem.addr;
   assign o_mem_wdata             = mem.wdata;
   assign o_op_ready              = !rmw_busy;
   assign o_wdt_clear             = wdt_clear_reg;
   assign o_watchdog_timeout_flag = timeout_reg;
   assign o_power_down_flag       = power_down_reg;

   // Cycles with ready withheld, whether or not an instruction waits; a stuck sequence would freeze the core silently
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         stall_cnt_reg <= 2'h0;
      end else if (!o_op_ready) begin
         stall_cnt_reg <= stall_cnt_reg + 2'h1;
      end else begin
         stall_cnt_reg <= 2'h0;
      end
   end

   // Pre-clear pairing and flag checks
   clear_flags_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE1]
      clear_fire && !i_timeout_set && !i_power_down_set |=>
      o_wdt_clear && !o_watchdog_timeout_flag && !o_power_down_flag)
      else $error("effective pre-clear did not clear");
   second_alone_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE3]
      is_second && pair_reg != preclear_pkg::PAIR_FIRST |=> !o_wdt_clear)
      else $error("repeated second pre-clear took effect");
   first_alone_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE4]
      is_first && pair_reg != preclear_pkg::PAIR_SECOND |=> !o_wdt_clear)
      else $error("repeated first pre-clear took effect");
   pair_alternate_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE2]
      is_first && pair_reg != preclear_pkg::PAIR_SECOND ##1 is_second |=> o_wdt_clear)
      else $error("alternating pair did not clear");
   flag_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE3]
      !clear_fire && !i_timeout_set |=> $stable(o_watchdog_timeout_flag))
      else $error("time-out flag changed without cause");
   // A lone first half arms the pair
   pair_first_track_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE4]
      is_first && pair_reg != preclear_pkg::PAIR_SECOND |=> pair_reg == preclear_pkg::PAIR_FIRST)
      else $error("first pre-clear not remembered");
   // A lone second half arms the pair
   pair_second_track_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE3]
      is_second && pair_reg != preclear_pkg::PAIR_FIRST |=> pair_reg == preclear_pkg::PAIR_SECOND)
      else $error("second pre-clear not remembered");
   // Both halves needed again after a clear
   pair_rearm_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE2]
      clear_fire |=> pair_reg == preclear_pkg::PAIR_RESET)
      else $error("pair not rearmed after clear");
   // Other instructions leave the pairing alone
   pair_idle_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE2]
      !is_first && !is_second |=> $stable(pair_reg))
      else $error("pairing changed without a pre-clear");
   // Unused pairing code never reached
   pair_legal_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE2]
      pair_reg != 2'h3)
      else $error("illegal pairing state");
   // Counter clear is a single pulse
   clear_single_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE1]
      o_wdt_clear |=> !o_wdt_clear)
      else $error("clear pulse longer than one cycle");
   // No pulse without an effective pre-clear
   no_cause_clear_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE3]
      !clear_fire |=> !o_wdt_clear)
      else $error("clear pulse without cause");
   // Power-down flag keeps its value without cause
   pd_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE4]
      !clear_fire && !i_power_down_set |=> $stable(o_power_down_flag))
      else $error("power-down flag changed without cause");
   // Hardware set wins over a clear in the same cycle
   to_set_wins_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE1]
      i_timeout_set |=> o_watchdog_timeout_flag)
      else $error("time-out set lost");
   // Same for the power-down flag
   pd_set_wins_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE1]
      i_power_down_set |=> o_power_down_flag)
      else $error("power-down set lost");
   // Power-down flag cleared by an effective pre-clear
   pd_clear_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE1]
      clear_fire && !i_power_down_set |=> !o_power_down_flag)
      else $error("power-down flag not cleared");

   // Memory sequence checks
   cpl_start_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE6]
      is_cpl |=> o_mem_rd_en && o_mem_addr == $past(i_op_addr) ##1 o_mem_wr_en)
      else $error("complement sequence not started");
   cpl_value_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE5]
      o_mem_rd_en |=> o_mem_wdata == ~$past(i_mem_rdata))
      else $error("complement value wrong");
   busy_stall_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE6]
      is_cpl |=> !o_op_ready [*2] ##1 o_op_ready)
      else $error("ready not withheld for two cycles");
   // Read and write never overlap
   rd_wr_apart_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE6]
      !(o_mem_rd_en && o_mem_wr_en))
      else $error("read and write at once");
   // Address holds from read to write
   rmw_addr_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE6]
      o_mem_rd_en |=> $stable(o_mem_addr))
      else $error("address moved between read and write");
   // A write only ever follows a read
   wr_after_rd_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE6]
      o_mem_wr_en |-> $past(o_mem_rd_en))
      else $error("write without preceding read");
   // A read only ever follows an accepted complement
   rd_after_take_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE5]
      o_mem_rd_en |-> $past(is_cpl))
      else $error("read without complement instruction");
   // Core released right after the write
   rmw_end_ready_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE6]
      o_mem_wr_en |=> o_op_ready)
      else $error("ready not restored after write");
   // Ready whenever the memory port is quiet
   ready_when_idle_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE6]
      !o_mem_rd_en && !o_mem_wr_en |-> o_op_ready)
      else $error("ready low with port idle");
   // Stall never outlasts the read-modify-write
   stall_bound_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [RULE6]
      stall_cnt_reg <= 2'(preclear_pkg::RMW_CYCLES))
      else $error("stall longer than the sequence");
endmodule // preclear_complement

// File: bench/tb_preclear_complement.sv
module tb_preclear_complement;
   timeunit 1ns;
   timeprecision 1ns;
   logic              core_clk = 1'b0;
   logic              rst = 1'b1;
   logic              op_valid = 1'b0;
   logic              to_set = 1'b0;
   logic              pd_set = 1'b0;
   preclear_pkg::op_t op = preclear_pkg::OP_NONE;
   logic [7:0]        op_addr = 8'h00;
   logic              op_ready, wdt_clear, to_flag, pd_flag, rd_en, wr_en, to_m, pd_m;
   logic [7:0]        mem_addr, mem_wdata, mem_rdata, a;
   logic [7:0]        mem_arr [256];
   logic [7:0]        model_mem [256];
   logic [7:0]        exp_q [$];
   localparam int     CYCLE_LIMIT = 6000;
   int                mismatches = 0, total_checks = 0, seed = 86, cycles = 0;
   int                pair_m = 0, k, n;
   preclear_pkg::op_t rop;
   preclear_pkg::op_t tbl [6] = '{preclear_pkg::OP_FIRST_PRECLEAR, preclear_pkg::OP_FIRST_PRECLEAR,
      preclear_pkg::OP_SECOND_PRECLEAR, preclear_pkg::OP_SECOND_PRECLEAR,
      preclear_pkg::OP_SECOND_PRECLEAR, preclear_pkg::OP_FIRST_PRECLEAR};

   // Byte-wide memory model matches these widths
   preclear_complement #(.AW(8), .DW(8)) DUT (
      .I_CORE_CLK              (core_clk),
      .I_RST                   (rst),
      .i_op_valid              (op_valid),
      .i_op                    (op),
      .i_op_addr               (op_addr),
      .i_timeout_set           (to_set),
      .i_power_down_set        (pd_set),
      .o_op_ready              (op_ready),
      .o_wdt_clear             (wdt_clear),
      .o_watchdog_timeout_flag (to_flag),
      .o_power_down_flag       (pd_flag),
      .o_mem_rd_en             (rd_en),
      .o_mem_wr_en             (wr_en),
      .o_mem_addr              (mem_addr),
      .o_mem_wdata             (mem_wdata),
      .i_mem_rdata             (mem_rdata)
   );

   // 50 ns core clock
   always #25 core_clk = ~core_clk;

   // Data memory: combinational read, write on the write cycle's edge
   assign mem_rdata = mem_arr[mem_addr];
   always @(posedge core_clk) begin
      if (wr_en === 1'b1) mem_arr[mem_addr] <= mem_wdata;
   end

   // Cycle ceiling: a hang ends as a failure
   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == CYCLE_LIMIT) begin
         mismatches = mismatches + 1;
         $display("unexpected %0t: cycle limit reached", $time);
         report_and_stop();
      end
   end

   task automatic check_clear(input logic exp);
      begin
         total_checks++;
         if (wdt_clear !== exp) begin
            mismatches++;
            $display("unexpected %0t: clear pulse %b, model %b", $time, wdt_clear, exp);
         end
      end
   endtask

   task automatic check_flags(input logic exp_to, input logic exp_pd);
      begin
         total_checks++;
         if (to_flag !== exp_to || pd_flag !== exp_pd) begin
            mismatches++;
            $display("unexpected %0t: flags %b%b, model %b%b", $time, to_flag, pd_flag,
                     exp_to, exp_pd);
         end
      end
   endtask

   task automatic check_strobe(input string what, input logic got, input logic exp);
      begin
         total_checks++;
         if (got !== exp) begin
            mismatches++;
            $display("unexpected %0t: %s %b, model %b", $time, what, got, exp);
         end
      end
   endtask

   task automatic check_byte(input string what, input logic [7:0] got, input logic [7:0] exp);
      begin
         total_checks++;
         if (got !== exp) begin
            mismatches++;
            $display("unexpected %0t: %s %h, model %h", $time, what, got, exp);
         end
      end
   endtask

   // One slot: drive at a falling edge, judge at the next; inputs stay until the next call
   task automatic issue(input logic v, input preclear_pkg::op_t o, input logic ts, input logic ps);
      logic exp_clr;
      begin
         op_valid = v;
         op       = o;
         to_set   = ts;
         pd_set   = ps;
         exp_clr  = 1'b0;
         if (v && o == preclear_pkg::OP_FIRST_PRECLEAR) begin
            exp_clr = (pair_m == 2);
            pair_m  = exp_clr ? 0 : 1;
         end else if (v && o == preclear_pkg::OP_SECOND_PRECLEAR) begin
            exp_clr = (pair_m == 1);
            pair_m  = exp_clr ? 0 : 2;
         end
         if (ts) to_m = 1'b1;
         else if (exp_clr) to_m = 1'b0;
         if (ps) pd_m = 1'b1;
         else if (exp_clr) pd_m = 1'b0;
         @(negedge core_clk);
         check_clear(exp_clr);
         check_flags(to_m, pd_m);
      end
   endtask

   // Complement: take, read cycle, write cycle, then ready again
   task automatic complement(input logic [7:0] ad);
      begin
         op_valid = 1'b1;
         op       = preclear_pkg::OP_COMPLEMENT;
         op_addr  = ad;
         to_set   = 1'b0;
         pd_set   = 1'b0;
         exp_q.push_back(~model_mem[ad]);
         model_mem[ad] = ~model_mem[ad];
         @(negedge core_clk);
         op_valid = 1'b0;
         op       = preclear_pkg::OP_NONE;
         check_strobe("read strobe", rd_en, 1'b1);
         check_strobe("ready in read", op_ready, 1'b0);
         check_byte("read address", mem_addr, ad);
         check_clear(1'b0);
         @(negedge core_clk);
         check_strobe("write strobe", wr_en, 1'b1);
         check_strobe("ready in write", op_ready, 1'b0);
         check_byte("write address", mem_addr, ad);
         check_byte("written byte", mem_wdata, exp_q.pop_front());
         @(negedge core_clk);
         check_strobe("ready after", op_ready, 1'b1);
         check_strobe("write after", wr_en, 1'b0);
         check_byte("memory byte", mem_arr[ad], model_mem[ad]);
         check_flags(to_m, pd_m);
      end
   endtask

   // Reset for a number of cycles; model forgets pairing and flags
   task automatic pulse_reset(input int len);
      begin
         rst      = 1'b1;
         op_valid = 1'b0;
         op       = preclear_pkg::OP_NONE;
         to_set   = 1'b0;
         pd_set   = 1'b0;
         repeat (len) @(negedge core_clk);
         rst    = 1'b0;
         pair_m = 0;
         to_m   = 1'b0;
         pd_m   = 1'b0;
         check_flags(to_m, pd_m);
         check_strobe("ready after reset", op_ready, 1'b1);
      end
   endtask

   task automatic report_and_stop;
      begin
         $display("checks %0d mismatches %0d", total_checks, mismatches);
         if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
         end else begin
            $display("SIMULATION FAILED");
         end
         $finish;
      end
   endtask

   initial begin
      for (k = 0; k < 256; k++) begin
         mem_arr[k]   = 8'($random(seed));
         model_mem[k] = mem_arr[k];
      end
      pulse_reset(6);
      // Raise both flags, then walk repeats and alternations of the pair
      issue(1'b1, preclear_pkg::OP_NONE, 1'b1, 1'b1);
      for (n = 0; n < 6; n++) issue(1'b1, tbl[n], 1'b0, 1'b0);
      // Same byte twice returns it to its first value
      complement(8'h5A);
      complement(8'h5A);
      complement(8'hFF);
      // Mid-run reset: pairing starts empty again
      pulse_reset(2);
      issue(1'b1, preclear_pkg::OP_SECOND_PRECLEAR, 1'b1, 1'b1);
      issue(1'b1, preclear_pkg::OP_FIRST_PRECLEAR, 1'b0, 1'b0);
      // Random instructions, flag sets and gaps
      for (n = 0; n < 400; n++) begin
         k   = $random(seed);
         a   = 8'(k >>> 16);
         rop = preclear_pkg::op_t'(k[1:0]);
         if (n == 200) pulse_reset(2);
         if (rop == preclear_pkg::OP_COMPLEMENT && k[3:2] != 2'h0) complement(a);
         else issue(k[3:2] != 2'h0, rop, k[7:4] == 4'h0, k[11:8] == 4'h0);
      end
      issue(1'b0, preclear_pkg::OP_NONE, 1'b0, 1'b0);
      report_and_stop();
   end
endmodule // tb_preclear_complement
